// >>> verilog/timer_capture_ppg_filter_pkg.sv
// Package: register map, field layouts, reset values and encodings of the timer channel
package timer_capture_ppg_filter_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_MODE     = 8'h00;
    localparam logic [7:0] OFF_CTRL     = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_A_LOW    = 8'h0c;
    localparam logic [7:0] OFF_A_HIGH   = 8'h10;
    localparam logic [7:0] OFF_B_LOW    = 8'h14;
    localparam logic [7:0] OFF_B_HIGH   = 8'h18;
    localparam logic [7:0] OFF_COUNTER  = 8'h1c;

    // ----------------------------------------------------------------
    // Field layouts; the member order fixes the bit positions
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] source_clock_select;   // [7:5]
        logic       capture_edge_mode;     // [4]
        logic       trigger_edge_select;   // [3]
        logic [2:0] operation_mode_field;  // [2:0]
    } timer_mode_t;

    typedef struct packed {
        logic [1:0] noise_filter_interval; // [6:5]
        logic       double_buffer_enable;  // [4]
        logic       output_initial_level;  // [3]
        logic       oneshot_select;        // [2]
        logic       overflow_irq_enable;   // [1]
        logic       run_bit;               // [0]
    } timer_ctrl_t;

    // Status bits: [0] capture_flag_a, [1] capture_flag_b, [2] overflow_flag
    localparam int FLAG_CAP_A = 0;
    localparam int FLAG_CAP_B = 1;
    localparam int FLAG_OVF   = 2;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [7:0]  MODE_RESET = 8'h00;
    localparam logic [6:0]  CTRL_RESET = 7'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [2:0]  OP_PULSE_WIDTH = 3'h6;
    localparam logic [2:0]  OP_PULSE_GEN   = 3'h3;
    localparam logic [1:0]  NF_OFF    = 2'h0;
    localparam logic [1:0]  NF_DIV2   = 2'h1;
    localparam logic [1:0]  NF_DIV4   = 2'h2;
    localparam logic [1:0]  NF_DIV256 = 2'h3;

    // Sampling interval masks on the gear-clock prescaler: 2, 4, 256 cycles
    localparam logic [10:0] NF_MASK_DIV2   = 11'h001;
    localparam logic [10:0] NF_MASK_DIV4   = 11'h003;
    localparam logic [10:0] NF_MASK_DIV256 = 11'h0ff;

    // Source clock divide masks: /2^11, /2^10, /2^8, /2^6, /2^4, /2^2, /2, /1
    function automatic logic [10:0] gear_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    gear_mask = 11'h7ff;
            3'h1:    gear_mask = 11'h3ff;
            3'h2:    gear_mask = 11'h0ff;
            3'h3:    gear_mask = 11'h03f;
            3'h4:    gear_mask = 11'h00f;
            3'h5:    gear_mask = 11'h003;
            3'h6:    gear_mask = 11'h001;
            default: gear_mask = 11'h000;
        endcase
    endfunction

    typedef enum logic [1:0] {PW_WAIT, PW_HIGH, PW_AFTER} pw_state_t;

endpackage

// >>> verilog/timer_capture_ppg_filter.sv
// Top module: 16-bit capture / pulse generator timer channel with input noise filter
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
//
// Overview of operation
// - Operation mode 110 measures pulse widths on the filtered timer input.
// - Trigger edge select 0 starts on rising edge, 1 on falling.
// - Capture edge mode 0 is double-edge, 1 is single-edge capture.
// - Starting clears both capture registers; mode and overflow enable locked while running.
// - Start edge interrupts and counts; opposite edge captures B, flags, interrupts.
// - Double-edge: next start edge captures A, flags, interrupts, clears counter.
// - Single-edge: opposite edge stops and clears; next start edge restarts.
// - Overflow while capturing sets flag; interrupt only if overflow enable set.
// - Reading status clears both capture flags and the overflow flag.
// - An opposite edge seen first after start is ignored entirely.
// - Clearing run during measurement stops and zeroes the counter.
// - Mode 011 generates pulses: A is period, B first toggle; A > B.
// - Initial level bit sets idle output; B match drives the opposite.
// - A match restores level, interrupts; one-shot stops, continuous clears counter.
// - Output returns to initial level whenever run drops during generation.
// - One-shot select stays writable; 0 continues, 1 stops after current pulse.
// - Low byte goes to a temporary byte; high byte write commits both.
// - Double buffer: running writes load at A match; reads give last written.
// - Without double buffer writes act at once; passed values wait for wrap.
// - Filter changes level after three equal samples at 2, 4 or 256 cycles.
// - Filter field locked while running; low-frequency mode: 11 halves slow clock, 01/10 block.
module timer_capture_ppg_filter
    import timer_capture_ppg_filter_pkg::*;
#(
    parameter int LF_DIV = 6104
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        TIMER_IN,
    input  wire logic        LOW_FREQ_MODE_IN,
    output logic             PULSE_OUT,
    output logic             TIMER_IRQ_OUT
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  sync;
        logic        lvl;
        logic [2:0]  smp;
        logic        filt;
        logic        filt_d;
        logic [10:0] pre;
        logic [15:0] lfc;
        logic        lft;
        logic [3:0]  lfpre;
        timer_mode_t mode;
        timer_ctrl_t ctrl;
        logic [2:0]  flags;
        logic [7:0]  tmp;
        logic [15:0] a_eff;
        logic [15:0] a_buf;
        logic [15:0] b_eff;
        logic [15:0] b_buf;
        logic [15:0] cnt;
        pw_state_t   pw;
        logic        pulse;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_t;

    state_t      s_reg;
    state_t      s_next;
    logic [2:0]  fset;
    logic        tick;
    logic        smp_tick;
    logic        start_e;
    logic        opp_e;
    logic        pwm_on;
    logic        ppg_on;
    logic        a_match;
    logic        wr;
    logic        rd_stat;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [15:0] wv;
    logic [2:0]  nsmp;
    timer_ctrl_t wc;

    assign pwm_on  = s_reg.ctrl.run_bit && s_reg.mode.operation_mode_field == OP_PULSE_WIDTH;
    assign ppg_on  = s_reg.ctrl.run_bit && s_reg.mode.operation_mode_field == OP_PULSE_GEN;
    assign start_e = s_reg.filt != s_reg.filt_d &&
                     s_reg.filt == ~s_reg.mode.trigger_edge_select;
    assign opp_e   = s_reg.filt != s_reg.filt_d && !start_e;
    assign a_match = ppg_on && tick && s_reg.cnt == s_reg.a_eff;

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (PADDR_IN)
            OFF_MODE:    rd_mux = {24'h00_0000, s_reg.mode};
            OFF_CTRL:    rd_mux = {25'h000_0000, s_reg.ctrl};
            OFF_STATUS:  rd_mux = {29'h0000_0000, s_reg.flags};
            OFF_A_LOW:   rd_mux = {16'h0000, s_reg.a_buf};
            OFF_A_HIGH:  rd_mux = {24'h00_0000, s_reg.a_buf[15:8]};
            OFF_B_LOW:   rd_mux = {16'h0000, s_reg.b_buf};
            OFF_B_HIGH:  rd_mux = {24'h00_0000, s_reg.b_buf[15:8]};
            OFF_COUNTER: rd_mux = {16'h0000, s_reg.cnt};
            default:     mapped = 1'b0;
        endcase
    end

    assign wr      = PSEL_IN && PENABLE_IN && s_reg.pready && PWRITE_IN && mapped;
    assign rd_stat = PSEL_IN && PENABLE_IN && s_reg.pready && !PWRITE_IN &&
                     PADDR_IN == OFF_STATUS;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        fset   = 3'h0;
        tick   = 1'b0;
        smp_tick = 1'b0;
        wv     = {PWDATA_IN[7:0], s_reg.tmp};
        wc     = timer_ctrl_t'(PWDATA_IN[6:0]);
        nsmp   = {s_reg.smp[1:0], s_reg.lvl};

        // Input synchroniser: level taken only once stages two and three agree
        s_next.sync = {s_reg.sync[1:0], TIMER_IN};
        if (s_reg.sync[1] == s_reg.sync[2]) begin
            s_next.lvl = s_reg.sync[2];
        end

        // Gear prescaler and low-frequency clock model
        s_next.pre = s_reg.pre + 11'h001;
        s_next.lft = s_reg.lfc == 16'(LF_DIV - 1);
        s_next.lfc = s_next.lft ? 16'h0000 : s_reg.lfc + 16'h0001;
        if (s_reg.lft) begin
            s_next.lfpre = s_reg.lfpre + 4'h1;
        end
        if (!LOW_FREQ_MODE_IN) begin
            tick = (s_reg.pre & gear_mask(s_reg.mode.source_clock_select)) ==
                   gear_mask(s_reg.mode.source_clock_select);
        end else begin
            case (s_reg.mode.source_clock_select)
                3'h0:    tick = s_reg.lft && s_reg.lfpre == 4'hf;
                3'h1:    tick = s_reg.lft && s_reg.lfpre[2:0] == 3'h7;
                3'h7:    tick = s_reg.lft && s_reg.lfpre[1:0] == 2'h3;
                default: tick = 1'b0;
            endcase
        end

        // Noise filter; runs regardless of the run bit
        case (s_reg.ctrl.noise_filter_interval)
            NF_DIV2:   smp_tick = !LOW_FREQ_MODE_IN && (s_reg.pre & NF_MASK_DIV2) == NF_MASK_DIV2;
            NF_DIV4:   smp_tick = !LOW_FREQ_MODE_IN && (s_reg.pre & NF_MASK_DIV4) == NF_MASK_DIV4;
            NF_DIV256: smp_tick = LOW_FREQ_MODE_IN ? s_reg.lft && s_reg.lfpre[0] :
                                  (s_reg.pre & NF_MASK_DIV256) == NF_MASK_DIV256;
            default:   smp_tick = 1'b0;
        endcase
        if (s_reg.ctrl.noise_filter_interval == NF_OFF) begin
            s_next.filt = s_reg.lvl;
        end else if (smp_tick) begin
            s_next.smp = nsmp;
            if (nsmp == 3'h7 || nsmp == 3'h0) begin
                s_next.filt = nsmp[0];
            end
        end
        s_next.filt_d = s_reg.filt;
        s_next.irq    = 1'b0;

        // Pulse width measurement
        if (pwm_on) begin
            if (s_reg.pw != PW_WAIT && tick) begin
                s_next.cnt = s_reg.cnt + 16'h0001;
                if (s_reg.cnt == 16'hffff) begin
                    fset[FLAG_OVF] = 1'b1;
                    s_next.irq = s_reg.ctrl.overflow_irq_enable;
                end
            end
            if (start_e) begin
                case (s_reg.pw)
                    PW_WAIT: begin
                        s_next.irq = 1'b1;
                        s_next.pw  = PW_HIGH;
                    end
                    PW_AFTER: begin
                        s_next.a_eff = s_reg.cnt;
                        s_next.a_buf = s_reg.cnt;
                        fset[FLAG_CAP_A] = 1'b1;
                        s_next.irq = 1'b1;
                        s_next.cnt = DATA_RESET;
                        s_next.pw  = PW_HIGH;
                    end
                    default: ;
                endcase
            end else if (opp_e && s_reg.pw == PW_HIGH) begin
                s_next.b_eff = s_reg.cnt;
                s_next.b_buf = s_reg.cnt;
                fset[FLAG_CAP_B] = 1'b1;
                s_next.irq = 1'b1;
                if (s_reg.mode.capture_edge_mode) begin
                    s_next.cnt = DATA_RESET;
                    s_next.pw  = PW_WAIT;
                end else begin
                    s_next.pw  = PW_AFTER;
                end
            end
        end

        // Pulse generation
        if (!ppg_on) begin
            s_next.pulse = s_reg.ctrl.output_initial_level;
        end else if (tick) begin
            if (a_match) begin
                s_next.pulse = s_reg.ctrl.output_initial_level;
                s_next.irq   = 1'b1;
                s_next.cnt   = DATA_RESET;
                if (s_reg.ctrl.double_buffer_enable) begin
                    s_next.a_eff = s_reg.a_buf;
                    s_next.b_eff = s_reg.b_buf;
                end
                if (s_reg.ctrl.oneshot_select) begin
                    s_next.ctrl.run_bit = 1'b0;
                end
            end else begin
                // Plain wrap: a compare value already passed waits a full roll
                s_next.cnt = s_reg.cnt + 16'h0001;
                if (s_reg.cnt == s_reg.b_eff) begin
                    s_next.pulse = ~s_reg.ctrl.output_initial_level;
                end
            end
        end

        // Register writes
        if (wr) begin
            case (PADDR_IN)
                OFF_MODE: begin
                    if (!s_reg.ctrl.run_bit) begin
                        s_next.mode = timer_mode_t'(PWDATA_IN[7:0]);
                    end
                end
                OFF_CTRL: begin
                    s_next.ctrl.run_bit = wc.run_bit;
                    s_next.ctrl.oneshot_select = wc.oneshot_select;
                    s_next.ctrl.double_buffer_enable = wc.double_buffer_enable;
                    if (!s_reg.ctrl.run_bit) begin
                        s_next.ctrl.overflow_irq_enable = wc.overflow_irq_enable;
                        s_next.ctrl.output_initial_level = wc.output_initial_level;
                        s_next.ctrl.noise_filter_interval = wc.noise_filter_interval;
                    end
                    if (wc.run_bit != s_reg.ctrl.run_bit) begin
                        s_next.cnt = DATA_RESET;
                        s_next.pw  = PW_WAIT;
                    end
                    if (wc.run_bit && !s_reg.ctrl.run_bit &&
                        s_reg.mode.operation_mode_field == OP_PULSE_WIDTH) begin
                        s_next.a_eff = DATA_RESET;
                        s_next.a_buf = DATA_RESET;
                        s_next.b_eff = DATA_RESET;
                        s_next.b_buf = DATA_RESET;
                    end
                end
                OFF_A_LOW, OFF_B_LOW: s_next.tmp = PWDATA_IN[7:0];
                OFF_A_HIGH: begin
                    s_next.a_buf = wv;
                    if (!(s_reg.ctrl.run_bit && s_reg.ctrl.double_buffer_enable)) begin
                        s_next.a_eff = wv;
                    end
                end
                OFF_B_HIGH: begin
                    s_next.b_buf = wv;
                    if (!(s_reg.ctrl.run_bit && s_reg.ctrl.double_buffer_enable)) begin
                        s_next.b_eff = wv;
                    end
                end
                default: ;
            endcase
        end

        // Status flags: a new event outranks the read that clears
        s_next.flags = (s_reg.flags & ~{3{rd_stat}}) | fset;

        // APB: one wait state so that every answer leaves a flip-flop
        s_next.pready  = PSEL_IN && PENABLE_IN && !s_reg.pready;
        s_next.pslverr = PSEL_IN && PENABLE_IN && !s_reg.pready && !mapped;
        if (PSEL_IN && PENABLE_IN && !s_reg.pready) begin
            s_next.prdata = PWRITE_IN ? 32'h0000_0000 : rd_mux;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RSTN_IN) begin
            s_reg      <= '0;
            s_reg.mode <= timer_mode_t'(MODE_RESET);
            s_reg.ctrl <= timer_ctrl_t'(CTRL_RESET);
            s_reg.pw   <= PW_WAIT;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PRDATA_OUT    = s_reg.prdata;
    assign PREADY_OUT    = s_reg.pready;
    assign PSLVERR_OUT   = s_reg.pslverr;
    assign PULSE_OUT     = s_reg.pulse;
    assign TIMER_IRQ_OUT = s_reg.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    run_clears_caps_a: assert property (
        wr && PADDR_IN == OFF_CTRL && PWDATA_IN[0] && !s_reg.ctrl.run_bit &&
        s_reg.mode.operation_mode_field == OP_PULSE_WIDTH
        |=> s_reg.a_buf == 16'h0000 && s_reg.b_buf == 16'h0000)
        else $error("capture registers not cleared at start");
    mode_locked_a: assert property (
        s_reg.ctrl.run_bit && $past(s_reg.ctrl.run_bit) |-> $stable(s_reg.mode))
        else $error("mode changed while running");
    capture_b_a: assert property (
        pwm_on && opp_e && s_reg.pw == PW_HIGH
        |=> s_reg.b_eff == $past(s_reg.cnt) && s_reg.flags[FLAG_CAP_B] && TIMER_IRQ_OUT)
        else $error("opposite edge did not capture into B");
    double_clear_a: assert property (
        pwm_on && start_e && s_reg.pw == PW_AFTER
        |=> s_reg.cnt == 16'h0000 && s_reg.flags[FLAG_CAP_A] && s_reg.pw == PW_HIGH)
        else $error("second start edge did not capture A and clear");
    single_stop_a: assert property (
        pwm_on && opp_e && s_reg.pw == PW_HIGH && s_reg.mode.capture_edge_mode
        |=> s_reg.pw == PW_WAIT ##1 s_reg.cnt == 16'h0000)
        else $error("single-edge capture did not stop");
    first_opp_ignored_a: assert property (
        pwm_on && opp_e && s_reg.pw == PW_WAIT && !tick |=> !TIMER_IRQ_OUT && $stable(s_reg.b_buf))
        else $error("leading opposite edge was acted on");
    ovf_flag_a: assert property (
        pwm_on && tick && s_reg.pw != PW_WAIT && s_reg.cnt == 16'hffff
        |=> s_reg.flags[FLAG_OVF] && s_reg.cnt == 16'h0000)
        else $error("overflow not flagged");
    status_clear_a: assert property (
        rd_stat |=> (s_reg.flags & ~$past(fset)) == 3'h0)
        else $error("status read did not clear flags");
    oneshot_stop_a: assert property (
        a_match && s_reg.ctrl.oneshot_select && !wr
        |=> !s_reg.ctrl.run_bit ##1 PULSE_OUT == s_reg.ctrl.output_initial_level)
        else $error("one-shot did not stop at A match");
    idle_level_a: assert property (
        !s_reg.ctrl.run_bit && $past(!s_reg.ctrl.run_bit) && $stable(s_reg.ctrl)
        |-> PULSE_OUT == s_reg.ctrl.output_initial_level)
        else $error("idle output not at initial level");
    filter_three_a: assert property (
        s_reg.ctrl.noise_filter_interval != NF_OFF && $changed(s_reg.filt)
        |-> $past(s_next.smp) == 3'h7 || $past(s_next.smp) == 3'h0)
        else $error("filter changed without three equal samples");

    cover_double_c: cover property (pwm_on && start_e && s_reg.pw == PW_AFTER);
    cover_oneshot_c: cover property (a_match && s_reg.ctrl.oneshot_select);
    cover_ovf_c:     cover property (fset[FLAG_OVF] && rd_stat);

endmodule

// >>> verification/timer_pin_partner.sv
// Partner model: pulse source on the timer input and load on the pulse output
`timescale 1ns/100ps
module timer_pin_partner (
    input  wire logic        clk_in,
    input  wire logic        idle_lvl_in,
    input  wire logic        pulse_in,
    output logic             pin_out,
    output logic             done_out,
    output logic      [15:0] width_out
);
    logic        last_idle;
    logic [15:0] cnt;
    initial begin
        pin_out = 1'b0;
        done_out = 1'b0;
        width_out = 16'h0000;
        cnt = 16'h0000;
        last_idle = 1'b0;
    end
    // Whole-cycle levels, changed just after an edge like a real source
    task automatic drive(input logic lvl, input int cycles);
        @(posedge clk_in);
        pin_out <= lvl;
        repeat (cycles - 1) @(posedge clk_in);
    endtask
    // A change of idle level restarts the count, so no false pulse is seen
    always @(posedge clk_in) begin
        last_idle <= idle_lvl_in;
        done_out <= 1'b0;
        if (idle_lvl_in !== last_idle) cnt <= 16'h0000;
        else if (pulse_in !== idle_lvl_in) cnt <= cnt + 16'h0001;
        else if (cnt != 16'h0000) begin
            width_out <= cnt;
            done_out <= 1'b1;
            cnt <= 16'h0000;
        end
    end
endmodule

// >>> verification/timer_capture_ppg_filter_tb_top.sv
// Testbench: APB driver, expectation queues and result monitor for the timer channel
`timescale 1ns/100ps
module timer_capture_ppg_filter_tb_top;
    import timer_capture_ppg_filter_pkg::*;
    typedef struct packed {logic [31:0] e; logic [31:0] m;} note_t;
    logic        clk = 1'b0;
    logic        rstn, psel, penable, pwrite, pready, pslverr, tin, pout, irq, idle, lfm, pdone;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] pwidth;
    int          n_fail = 0;
    int          n_tests = 0;
    int          irq_cnt = 0;
    note_t       rq[$];
    logic [15:0] pq[$];
    always #2.5 clk = ~clk;
    timer_capture_ppg_filter #(.LF_DIV(8)) i_timer_capture_ppg_filter (
        .SYS_CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TIMER_IN(tin),
        .LOW_FREQ_MODE_IN(lfm), .PULSE_OUT(pout), .TIMER_IRQ_OUT(irq));
    timer_pin_partner i_timer_pin_partner (.clk_in(clk), .idle_lvl_in(idle),
        .pulse_in(pout), .pin_out(tin), .done_out(pdone), .width_out(pwidth));
    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // No fixed wait count: only the watchdog ends a hung transfer
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Zero mask marks an unmapped read that must answer with an error
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back('{e, m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        apb(1'b1, a, {24'h0, v[7:0]});
        apb(1'b1, a + 8'h04, {24'h0, v[15:8]});
    endtask
    task automatic wait_irq();
        int i;
        for (i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
        if (i >= 4000) chk("irq wait", 32'h1, 32'h0);
        @(posedge clk);
    endtask
    // ----------------------------------------------------------------
    // Result monitor
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (irq === 1'b1) irq_cnt++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk("read data", rq[0].e, prdata & rq[0].m);
            chk("slave error", {31'h0, rq[0].m == 32'h0}, {31'h0, pslverr});
            void'(rq.pop_front());
        end
        if (pdone === 1'b1) begin
            chk("pulse width", {16'h0, pq[0]}, {16'h0, pwidth});
            void'(pq.pop_front());
        end
    end
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] a, b;
        logic        lvl;
        int          n;
        {rstn, psel, penable, pwrite, idle, lfm} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(9258));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(OFF_MODE, {24'h0, MODE_RESET}, 32'hff);
        rd(OFF_CTRL, {25'h0, CTRL_RESET}, 32'h7f);
        rd(OFF_STATUS, 32'h0, 32'h7);
        rd(OFF_A_LOW, {16'h0, DATA_RESET}, 32'hffff);
        rd(8'h20, 32'h0, 32'h0);
        apb(1'b1, OFF_MODE, 32'he3);
        for (int k = 0; k < 3; k++) begin
            a = 16'(6 + $urandom_range(30));
            b = 16'(1 + $urandom_range(int'(a) - 2));
            lvl = k[0];
            wr16(OFF_A_LOW, a);
            wr16(OFF_B_LOW, b);
            rd(OFF_A_LOW, {16'h0, a}, 32'hffff);
            apb(1'b1, OFF_CTRL, {28'h0, lvl, 3'h0});
            repeat (3) @(posedge clk);
            idle <= lvl;
            pq.push_back(a - b);
            apb(1'b1, OFF_CTRL, {28'h0, lvl, 3'h5});
            wait_irq();
            rd(OFF_CTRL, {28'h0, lvl, 3'h4}, 32'h7f);
        end
        // Continuous, double-buffered period change, then one-shot in mid-run
        wr16(OFF_A_LOW, 16'h0014);
        wr16(OFF_B_LOW, 16'h000a);
        pq.push_back(16'h000a);
        pq.push_back(16'h0014);
        apb(1'b1, OFF_CTRL, 32'h11);
        wr16(OFF_A_LOW, 16'h001e);
        rd(OFF_A_LOW, 32'h1e, 32'hffff);
        wait_irq();
        apb(1'b1, OFF_CTRL, 32'h15);
        wait_irq();
        rd(OFF_CTRL, 32'h14, 32'h7f);
        repeat (30) @(posedge clk);
        chk("pulse count", 32'h0, 32'(pq.size()));
        // Single-edge width capture through the 2-cycle filter
        i_timer_pin_partner.drive(1'b1, 20);
        apb(1'b1, OFF_MODE, 32'hf6);
        apb(1'b1, OFF_CTRL, 32'h20);
        repeat (8) @(posedge clk);
        apb(1'b1, OFF_CTRL, 32'h21);
        rd(OFF_A_LOW, 32'h0, 32'hffff);
        apb(1'b1, OFF_MODE, 32'h03);
        rd(OFF_MODE, 32'hf6, 32'hff);
        n = irq_cnt;
        i_timer_pin_partner.drive(1'b0, 30);
        chk("irq count", 32'(n), 32'(irq_cnt));
        i_timer_pin_partner.drive(1'b1, 34);
        i_timer_pin_partner.drive(1'b0, 30);
        chk("irq count", 32'(n + 2), 32'(irq_cnt));
        rd(OFF_STATUS, 32'h2, 32'h7);
        rd(OFF_STATUS, 32'h0, 32'h7);
        rd(OFF_B_LOW, 32'h20, 32'hfffc);
        apb(1'b1, OFF_CTRL, 32'h00);
        rd(OFF_COUNTER, 32'h0, 32'hffff);
        // Double-edge capture: high 20, low 16, period 36 cycles
        apb(1'b1, OFF_MODE, 32'he6);
        apb(1'b1, OFF_CTRL, 32'h21);
        n = irq_cnt;
        i_timer_pin_partner.drive(1'b1, 20);
        i_timer_pin_partner.drive(1'b0, 16);
        i_timer_pin_partner.drive(1'b1, 20);
        chk("irq count", 32'(n + 3), 32'(irq_cnt));
        rd(OFF_STATUS, 32'h3, 32'h7);
        rd(OFF_A_LOW, 32'h20, 32'hfff8);
        rd(OFF_B_LOW, 32'h10, 32'hfff8);
        apb(1'b1, OFF_CTRL, 32'h00);
        // Low-frequency mode with the short filter interval blocks the pin
        lfm <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h21);
        n = irq_cnt;
        i_timer_pin_partner.drive(1'b0, 20);
        i_timer_pin_partner.drive(1'b1, 20);
        chk("irq count", 32'(n), 32'(irq_cnt));
        apb(1'b1, OFF_CTRL, 32'h00);
        lfm <= 1'b0;
        end_of_test();
    end
endmodule
